// >>> pkg/fault_status_pkg.sv
// package: register map, reset values and event carrier for the latched fault status block
`default_nettype none
package fault_status_pkg;

   // register offsets on the control port
   localparam logic [7:0] ADDR_MASK_ZERO     = 8'h2F;
   localparam logic [7:0] ADDR_MASK_FOUR     = 8'h32;
   localparam logic [7:0] ADDR_LATCHED_ZERO  = 8'h34;
   localparam logic [7:0] ADDR_CH_SUMMARY    = 8'h35;
   localparam logic [7:0] ADDR_CH_ONE_FAULT  = 8'h38;
   localparam logic [7:0] ADDR_CH_TWO_FAULT  = 8'h39;
   localparam logic [7:0] ADDR_LATCHED_ONE   = 8'h3A;

   // field positions
   localparam int CLOCK_ERROR_BIT     = 7;
   localparam int PLL_LOCK_BIT        = 6;
   localparam int SUMMARY_CH_ONE_BIT  = 5;
   localparam int SUMMARY_CH_TWO_BIT  = 4;
   localparam int POS_SHORT_BIT       = 7;
   localparam int NEG_SHORT_BIT       = 6;
   localparam int POS_VGND_BIT        = 5;
   localparam int NEG_VGND_BIT        = 4;
   localparam int REG_SHORT_MASK_BIT  = 1;
   localparam int REG_SHORT_BIT       = 0;
   localparam int INSERT_BIT          = 3;
   localparam int REMOVE_BIT          = 2;
   localparam int HOOK_BIT            = 1;
   localparam int MASK_SHORT_BIT      = 5;
   localparam int MASK_VGND_BIT       = 4;

   // values after reset
   localparam logic [1:0] MASK_ZERO_RESET    = 2'h3;
   localparam logic [4:0] MASK_FOUR_RESET    = 5'h00;
   localparam logic       REG_MASK_RESET     = 1'b0;
   localparam logic [7:0] RDATA_RESET        = 8'h00;
   localparam logic [7:0] UNMAPPED_READ      = 8'h00;

   // one bit per hardware event, high in each cycle the event is present
   typedef struct packed {
      logic clock_error;
      logic pll_lock;
      logic ch_one_pos_short;
      logic ch_one_neg_short;
      logic ch_one_pos_vgnd;
      logic ch_one_neg_vgnd;
      logic ch_two_pos_short;
      logic ch_two_neg_short;
      logic ch_two_pos_vgnd;
      logic ch_two_neg_vgnd;
      logic regulator_short;
      logic headset_insert;
      logic headset_remove;
      logic hook_press;
   } fault_events_s;

endpackage
`default_nettype wire

// >>> rtl/sticky_flag_bank.sv
// module: bank of sticky flags that set on an event and clear when their register is read
`timescale 1ns/1ps
`default_nettype none
module sticky_flag_bank #(
   parameter int WIDTH = 4
) (
   input  wire logic             core_clk_in,
   input  wire logic             nrst_in,
   input  wire logic [WIDTH-1:0] set_in,
   input  wire logic             clear_in,
   output logic      [WIDTH-1:0] flags_out
);

   logic [WIDTH-1:0] flags_q;
   logic [WIDTH-1:0] flags_d;

   // a set arriving in the clearing cycle wins, so no event is lost
   always_comb begin
      flags_d = clear_in ? set_in : (flags_q | set_in);
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         flags_q <= '0;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign flags_out = flags_q;

   a_set_wins_clear : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (set_in != '0) |=> ((flags_q & $past(set_in)) == $past(set_in)))
      else $error("sticky flag missed an event");

endmodule // sticky_flag_bank
`default_nettype wire

// >>> rtl/latched_fault_interrupt_status.sv
// module: latched interrupt and output fault status registers with interrupt request
//
// Summary of operation
// - clock error latches into bit 7 of register 0x34, self-clearing.
// - pll lock event latches into bit 6 of register 0x34, self-clearing.
// - bit 5 of 0x35 reads 1 when any channel 1 fault occurred.
// - bit 4 of 0x35 reads 1 when any channel 2 output short or virtual ground fault occurred.
// - channel 1 positive output short latches into bit 7 of 0x38.
// - channel 1 negative output short latches into bit 6 of 0x38.
// - channel 1 driver virtual ground faults latch into bits 5 and 4.
// - channel 2 output shorts latch into bits 7 and 6 of 0x39.
// - channel 2 driver virtual ground faults latch into bits 5 and 4.
// - bit 1 of 0x39 is a writable regulator short mask, reset 0.
// - bit 0 of 0x39 latches an analog regulator short, self-clearing.
// - headset insertion latches into bit 3 of register 0x3A.
// - headset removal latches into bit 2 of register 0x3A.
// - headset hook button press latches into bit 1 of 0x3A.
// - clock error interrupt mask, 1 masks, resets masked.
// - headset insertion interrupt mask, 1 masks, resets to 0.
// - output short fault interrupt mask, 1 masks, resets to 0.
`timescale 1ns/1ps
`default_nettype none
module latched_fault_interrupt_status (
   input  wire logic                           core_clk_in,
   input  wire logic                           nrst_in,
   input  wire fault_status_pkg::fault_events_s events_in,
   input  wire logic [7:0]                     reg_addr_in,
   input  wire logic                           reg_wr_in,
   input  wire logic [7:0]                     reg_wdata_in,
   input  wire logic                           reg_rd_in,
   output logic      [7:0]                     reg_rdata_out,
   output logic                                irq_out
);

   // address match on the control port
   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
      addr_hit = (addr == offset);
   endfunction

   // decoded strobes
   logic rd_lat0;
   logic rd_ch1;
   logic rd_ch2;
   logic rd_lat1;
   logic wr_mask0;
   logic wr_mask4;
   logic wr_ch2;

   // sticky flags and their set vectors
   logic [1:0] lat0_set;
   logic [1:0] lat0_flags;
   logic [3:0] ch1_set;
   logic [3:0] ch1_flags;
   logic [4:0] ch2_set;
   logic [4:0] ch2_flags;
   logic [2:0] lat1_set;
   logic [2:0] lat1_flags;

   // mask registers
   logic [1:0] mask_zero_q;
   logic [4:0] mask_four_q;
   logic       reg_mask_q;

   // assembled register images
   logic [7:0] lat0_image;
   logic [7:0] summary_image;
   logic [7:0] ch1_image;
   logic [7:0] ch2_image;
   logic [7:0] lat1_image;
   logic [7:0] mask0_image;
   logic [7:0] mask4_image;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;

   // read and write decode; a read of a latched register is also its clear
   assign rd_lat0  = reg_rd_in && addr_hit(reg_addr_in, fault_status_pkg::ADDR_LATCHED_ZERO);
   assign rd_ch1   = reg_rd_in && addr_hit(reg_addr_in, fault_status_pkg::ADDR_CH_ONE_FAULT);
   assign rd_ch2   = reg_rd_in && addr_hit(reg_addr_in, fault_status_pkg::ADDR_CH_TWO_FAULT);
   assign rd_lat1  = reg_rd_in && addr_hit(reg_addr_in, fault_status_pkg::ADDR_LATCHED_ONE);
   assign wr_mask0 = reg_wr_in && addr_hit(reg_addr_in, fault_status_pkg::ADDR_MASK_ZERO);
   assign wr_mask4 = reg_wr_in && addr_hit(reg_addr_in, fault_status_pkg::ADDR_MASK_FOUR);
   assign wr_ch2   = reg_wr_in && addr_hit(reg_addr_in, fault_status_pkg::ADDR_CH_TWO_FAULT);

   // event vectors, ordered high bit first as in each register
   assign lat0_set = {events_in.clock_error, events_in.pll_lock};
   assign ch1_set  = {events_in.ch_one_pos_short, events_in.ch_one_neg_short,
                      events_in.ch_one_pos_vgnd, events_in.ch_one_neg_vgnd};
   assign ch2_set  = {events_in.ch_two_pos_short, events_in.ch_two_neg_short,
                      events_in.ch_two_pos_vgnd, events_in.ch_two_neg_vgnd,
                      events_in.regulator_short};
   assign lat1_set = {events_in.headset_insert, events_in.headset_remove,
                      events_in.hook_press};

   // one bank per readable latched register, cleared by reading it
   sticky_flag_bank #(.WIDTH(2)) u_lat0 (
      .core_clk_in (core_clk_in),
      .nrst_in     (nrst_in),
      .set_in      (lat0_set),
      .clear_in    (rd_lat0),
      .flags_out   (lat0_flags)
   );

   sticky_flag_bank #(.WIDTH(4)) u_ch1 (
      .core_clk_in (core_clk_in),
      .nrst_in     (nrst_in),
      .set_in      (ch1_set),
      .clear_in    (rd_ch1),
      .flags_out   (ch1_flags)
   );

   sticky_flag_bank #(.WIDTH(5)) u_ch2 (
      .core_clk_in (core_clk_in),
      .nrst_in     (nrst_in),
      .set_in      (ch2_set),
      .clear_in    (rd_ch2),
      .flags_out   (ch2_flags)
   );

   sticky_flag_bank #(.WIDTH(3)) u_lat1 (
      .core_clk_in (core_clk_in),
      .nrst_in     (nrst_in),
      .set_in      (lat1_set),
      .clear_in    (rd_lat1),
      .flags_out   (lat1_flags)
   );

   // interrupt mask register zero; only the two defined bits are stored
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mask_zero_q <= fault_status_pkg::MASK_ZERO_RESET;
      end else if (wr_mask0) begin
         mask_zero_q <= reg_wdata_in[7:6];
      end
   end

   // interrupt mask register four, bits 5 down to 1
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mask_four_q <= fault_status_pkg::MASK_FOUR_RESET;
      end else if (wr_mask4) begin
         mask_four_q <= reg_wdata_in[5:1];
      end
   end

   // regulator short mask lives in the channel 2 register; other bits ignore writes
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         reg_mask_q <= fault_status_pkg::REG_MASK_RESET;
      end else if (wr_ch2) begin
         reg_mask_q <= reg_wdata_in[fault_status_pkg::REG_SHORT_MASK_BIT];
      end
   end

   // register images; reserved bits are forced to zero
   always_comb begin
      lat0_image = 8'h00;
      lat0_image[fault_status_pkg::CLOCK_ERROR_BIT] = lat0_flags[1];
      lat0_image[fault_status_pkg::PLL_LOCK_BIT]    = lat0_flags[0];
      summary_image = 8'h00;
      summary_image[fault_status_pkg::SUMMARY_CH_ONE_BIT] = |ch1_flags;
      summary_image[fault_status_pkg::SUMMARY_CH_TWO_BIT] = |ch2_flags[4:1];
      ch1_image = {ch1_flags, 4'h0};
      ch2_image = {ch2_flags[4:1], 2'h0, reg_mask_q, ch2_flags[0]};
      lat1_image = {4'h0, lat1_flags, 1'b0};
      mask0_image = {mask_zero_q, 6'h00};
      mask4_image = {2'h0, mask_four_q, 1'b0};
   end

   // read multiplexer; unmapped offsets answer zero
   always_comb begin
      case (reg_addr_in)
         fault_status_pkg::ADDR_MASK_ZERO:    rdata_d = mask0_image;
         fault_status_pkg::ADDR_MASK_FOUR:    rdata_d = mask4_image;
         fault_status_pkg::ADDR_LATCHED_ZERO: rdata_d = lat0_image;
         fault_status_pkg::ADDR_CH_SUMMARY:   rdata_d = summary_image;
         fault_status_pkg::ADDR_CH_ONE_FAULT: rdata_d = ch1_image;
         fault_status_pkg::ADDR_CH_TWO_FAULT: rdata_d = ch2_image;
         fault_status_pkg::ADDR_LATCHED_ONE:  rdata_d = lat1_image;
         default:                             rdata_d = fault_status_pkg::UNMAPPED_READ;
      endcase
   end

   // read data is captured in the same edge that clears the flags, so the host
   // always sees the value from before the clear
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_q <= fault_status_pkg::RDATA_RESET;
      end else if (reg_rd_in) begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_out = rdata_q;

   // interrupt request from registered flags and masks, so no glitch reaches the pin;
   // the summary bits are not sources since they only repeat channel flags
   assign irq_out =
      (lat0_flags[1] && !mask_zero_q[1])
      || (lat0_flags[0] && !mask_zero_q[0])
      || ((ch1_flags[3] || ch1_flags[2] || ch2_flags[4] || ch2_flags[3])
          && !mask_four_q[fault_status_pkg::MASK_SHORT_BIT - 1])
      || ((ch1_flags[1] || ch1_flags[0] || ch2_flags[2] || ch2_flags[1])
          && !mask_four_q[fault_status_pkg::MASK_VGND_BIT - 1])
      || (lat1_flags[2] && !mask_four_q[fault_status_pkg::INSERT_BIT - 1])
      || (lat1_flags[1] && !mask_four_q[fault_status_pkg::REMOVE_BIT - 1])
      || (lat1_flags[0] && !mask_four_q[fault_status_pkg::HOOK_BIT - 1])
      || (ch2_flags[0] && !reg_mask_q);

   // checks on latching, read-back and interrupt behaviour
   a_clock_error_latch : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      events_in.clock_error |=> reg_rd_in && addr_hit(reg_addr_in,
         fault_status_pkg::ADDR_LATCHED_ZERO) |=> reg_rdata_out[7])
      else $error("clock error not read back as latched");

   a_pll_lock_latch : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      events_in.pll_lock |=> lat0_image[6])
      else $error("pll lock event not latched");

   a_summary_ch_one : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (reg_rd_in && reg_addr_in == 8'h35 && ch1_image[7:4] != 4'h0) |=> reg_rdata_out[5])
      else $error("channel one summary missing");

   a_summary_ch_two : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (reg_rd_in && reg_addr_in == 8'h35) |=>
         (reg_rdata_out[4] == ($past(ch2_image[7:4]) != 4'h0)))
      else $error("channel two summary wrong");

   a_ch_one_shorts : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (events_in.ch_one_pos_short && events_in.ch_one_neg_short) |=> (ch1_image[7:6] == 2'h3))
      else $error("channel one short not latched");

   a_ch_one_vgnd : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      events_in.ch_one_neg_vgnd |=> ch1_image[4] [*1] ##1 (ch1_image[4] || $past(rd_ch1)))
      else $error("channel one virtual ground fault not held");

   a_ch_two_faults : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (events_in.ch_two_pos_short || events_in.ch_two_pos_vgnd) |=> irq_out ||
         mask_four_q[4] || mask_four_q[3])
      else $error("channel two fault lost its request");

   a_reg_mask_write : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (reg_wr_in && reg_addr_in == 8'h39) |=> (ch2_image[1] == $past(reg_wdata_in[1])))
      else $error("regulator mask write not stored");

   a_regulator_short : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (events_in.regulator_short && !reg_mask_q && !wr_ch2) |=> irq_out)
      else $error("regulator short did not raise request");

   a_headset_events : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (events_in.headset_insert && events_in.headset_remove && events_in.hook_press)
         |=> (lat1_image == 8'h0E))
      else $error("headset events not latched");

   a_reserved_zero : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (reg_rd_in && reg_addr_in == 8'h3A) |=> (reg_rdata_out[7:4] == 4'h0 && !reg_rdata_out[0]))
      else $error("reserved bits read nonzero");

   a_clear_on_read : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (rd_ch1 && ch1_set == 4'h0) |=> (ch1_image == 8'h00))
      else $error("read did not clear channel one flags");

   a_hold_until_read : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (lat1_image[3] && !rd_lat1) |=> lat1_image[3])
      else $error("latched bit dropped without a read");

   a_masked_clock : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (lat0_image == 8'h80 && mask_zero_q[1] && ch1_flags == 4'h0 && ch2_flags == 5'h00
         && lat1_flags == 3'h0) |-> !irq_out)
      else $error("masked clock error raised request");

   a_insert_unmasked : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (lat1_image[3] && !mask4_image[3]) |-> irq_out)
      else $error("unmasked insertion gave no request");

   a_short_unmasked : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (ch1_image[7] && !mask4_image[5]) |-> irq_out)
      else $error("unmasked short gave no request");

   // every request source on its own, since one stuck mask term hides behind the others
   a_clock_unmasked : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (lat0_image[7] && !mask0_image[7]) |-> irq_out)
      else $error("unmasked clock error gave no request");

   a_pll_unmasked : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (lat0_image[6] && !mask0_image[6]) |-> irq_out)
      else $error("unmasked pll lock gave no request");

   a_vgnd_unmasked : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      ((ch1_image[5:4] != 2'h0 || ch2_image[5:4] != 2'h0) && !mask4_image[4]) |-> irq_out)
      else $error("unmasked virtual ground fault gave no request");

   a_remove_unmasked : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (lat1_image[2] && !mask4_image[2]) |-> irq_out)
      else $error("unmasked removal gave no request");

   a_hook_unmasked : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (lat1_image[1] && !mask4_image[1]) |-> irq_out)
      else $error("unmasked hook press gave no request");

   a_reg_hold : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (ch2_image[0] && !rd_ch2) |=> ch2_image[0])
      else $error("regulator short dropped without a read");

   a_irq_quiet : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (lat0_flags == 2'h0 && ch1_flags == 4'h0 && ch2_flags == 5'h00 && lat1_flags == 3'h0)
         |-> !irq_out)
      else $error("request raised with no latched bit");

   // mask write-back; only the defined bits may take the written value
   a_mask_zero_write : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      wr_mask0 |=> (mask0_image == {$past(reg_wdata_in[7:6]), 6'h00}))
      else $error("mask zero write not stored");

   a_mask4_write : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      wr_mask4 |=> (mask4_image == ($past(reg_wdata_in) & 8'h3E)))
      else $error("mask four write not stored");

   a_write_ignored : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (reg_wr_in && !reg_rd_in && reg_addr_in == fault_status_pkg::ADDR_CH_ONE_FAULT
         && ch1_set == 4'h0) |=> (ch1_image == $past(ch1_image)))
      else $error("write changed channel one flags");

   // the summary is only a view, so reading it must not clear the channel flags
   a_summary_kept : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (reg_rd_in && reg_addr_in == fault_status_pkg::ADDR_CH_SUMMARY)
         |=> ((ch1_image & $past(ch1_image)) == $past(ch1_image)))
      else $error("summary read cleared channel one flags");

   a_rdata_holds : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      !reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data changed without a read");

   // reserved fields of every latched register read back as zero
   a_lat0_reserved : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (reg_rd_in && reg_addr_in == fault_status_pkg::ADDR_LATCHED_ZERO)
         |=> (reg_rdata_out[5:0] == 6'h00))
      else $error("latched zero reserved bits nonzero");

   a_summary_reserved : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (reg_rd_in && reg_addr_in == fault_status_pkg::ADDR_CH_SUMMARY)
         |=> (reg_rdata_out[7:6] == 2'h0 && reg_rdata_out[3:0] == 4'h0))
      else $error("summary reserved bits nonzero");

   a_ch1_reserved : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (reg_rd_in && reg_addr_in == fault_status_pkg::ADDR_CH_ONE_FAULT)
         |=> (reg_rdata_out[3:0] == 4'h0))
      else $error("channel one reserved bits nonzero");

   a_ch2_reserved : assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (reg_rd_in && reg_addr_in == fault_status_pkg::ADDR_CH_TWO_FAULT)
         |=> (reg_rdata_out[3:2] == 2'h0))
      else $error("channel two reserved bits nonzero");

endmodule // latched_fault_interrupt_status
`default_nettype wire

// >>> verif/latched_fault_interrupt_status_tb.sv
// testbench: reset values, event latching, read clearing and interrupt masking of the status block
`timescale 1ns/1ps
`default_nettype none
module latched_fault_interrupt_status_tb;
   logic                            core_clk_in;
   logic                            nrst_in;
   fault_status_pkg::fault_events_s events_in;
   logic [7:0]                      reg_addr_in;
   logic                            reg_wr_in;
   logic [7:0]                      reg_wdata_in;
   logic                            reg_rd_in;
   logic [7:0]                      reg_rdata_out;
   logic                            irq_out;
   int                              fail_count;
   int                              cmp_count;
   int                              cycle_count;
   logic [7:0]                      rd_data;

   latched_fault_interrupt_status dut (
      .core_clk_in   (core_clk_in),
      .nrst_in       (nrst_in),
      .events_in     (events_in),
      .reg_addr_in   (reg_addr_in),
      .reg_wr_in     (reg_wr_in),
      .reg_wdata_in  (reg_wdata_in),
      .reg_rd_in     (reg_rd_in),
      .reg_rdata_out (reg_rdata_out),
      .irq_out       (irq_out)
   );

   // 25 MHz control clock
   initial core_clk_in = 1'b0;
   always #20 core_clk_in = ~core_clk_in;

   // verdict and end of run, reached from the main sequence or the hang guard
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge core_clk_in) begin
      cycle_count++;
      if (cycle_count >= 3000) begin
         fail_count++;
         final_report();
      end
   end

   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic check1(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one read strobe; data is taken at the falling edge after the sampling edge
   task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
      @(negedge core_clk_in);
      reg_addr_in = addr;
      reg_rd_in = 1'b1;
      @(negedge core_clk_in);
      reg_rd_in = 1'b0;
      data = reg_rdata_out;
   endtask

   task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
      @(negedge core_clk_in);
      reg_addr_in = addr;
      reg_wdata_in = data;
      reg_wr_in = 1'b1;
      @(negedge core_clk_in);
      reg_wr_in = 1'b0;
   endtask

   // events present for exactly one clock edge
   task automatic pulse(input logic [13:0] ev);
      @(negedge core_clk_in);
      events_in = fault_status_pkg::fault_events_s'(ev);
      @(negedge core_clk_in);
      events_in = fault_status_pkg::fault_events_s'(14'h0000);
   endtask

   // register and bit of each event, index counted from the struct's lsb
   task automatic event_loc(input int idx, output logic [7:0] addr, output logic [7:0] bits);
      if (idx >= 12) begin
         addr = 8'h34;
         bits = 8'h01 << (idx - 6);
      end else if (idx >= 8) begin
         addr = 8'h38;
         bits = 8'h01 << (idx - 4);
      end else if (idx >= 4) begin
         addr = 8'h39;
         bits = 8'h01 << idx;
      end else if (idx == 3) begin
         addr = 8'h39;
         bits = 8'h01;
      end else begin
         addr = 8'h3A;
         bits = 8'h01 << (idx + 1);
      end
   endtask

   task automatic test_reset_values();
      logic [7:0] addrs [8] = '{8'h34, 8'h35, 8'h38, 8'h39, 8'h3A, 8'h2F, 8'h32, 8'h50};
      logic [7:0] exps  [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'h00, 8'h00};
      check1(irq_out, 1'b0);
      for (int i = 0; i < 8; i++) begin
         reg_read(addrs[i], rd_data);
         check8(rd_data, exps[i]);
      end
      $display("test reset values done");
   endtask

   task automatic test_each_event();
      logic [7:0] addr;
      logic [7:0] bits;
      for (int i = 0; i < 14; i++) begin
         event_loc(i, addr, bits);
         pulse(14'h0001 << i);
         check1(irq_out, logic'(i < 12));
         reg_read(8'h35, rd_data);
         check8(rd_data, (i >= 8 && i <= 11) ? 8'h20 : (i >= 4 && i <= 7) ? 8'h10 : 8'h00);
         reg_read(addr, rd_data);
         check8(rd_data, bits);
         reg_read(addr, rd_data);
         check8(rd_data, 8'h00);
         check1(irq_out, 1'b0);
      end
      $display("test each event done");
   endtask

   task automatic test_masks();
      reg_write(8'h32, 8'h3E);
      reg_write(8'h39, 8'h02);
      pulse(14'h0FFF);
      check1(irq_out, 1'b0);
      reg_read(8'h39, rd_data);
      check8(rd_data, 8'hF3);
      reg_write(8'h32, 8'h00);
      check1(irq_out, 1'b1);
      reg_read(8'h38, rd_data);
      check8(rd_data, 8'hF0);
      reg_read(8'h3A, rd_data);
      check8(rd_data, 8'h0E);
      check1(irq_out, 1'b0);
      reg_write(8'h38, 8'hF0);
      reg_read(8'h38, rd_data);
      check8(rd_data, 8'h00);
      pulse(14'h2000);
      check1(irq_out, 1'b0);
      reg_write(8'h2F, 8'h00);
      check1(irq_out, 1'b1);
      reg_read(8'h2F, rd_data);
      check8(rd_data, 8'h00);
      reg_read(8'h34, rd_data);
      check8(rd_data, 8'h80);
      check1(irq_out, 1'b0);
      $display("test masks done");
   endtask

   // a read that meets a still-present event must not lose it
   task automatic test_set_wins();
      @(negedge core_clk_in);
      events_in = fault_status_pkg::fault_events_s'(14'h0001);
      reg_read(8'h3A, rd_data);
      check8(rd_data, 8'h02);
      reg_read(8'h3A, rd_data);
      events_in = fault_status_pkg::fault_events_s'(14'h0000);
      check8(rd_data, 8'h02);
      reg_read(8'h3A, rd_data);
      check8(rd_data, 8'h02);
      reg_read(8'h3A, rd_data);
      check8(rd_data, 8'h00);
      $display("test set wins done");
   endtask

   // pll request path, reserved mask bits, regulator mask and a reset in mid-run
   task automatic test_pll_and_reset();
      reg_write(8'h2F, 8'hFF);
      reg_read(8'h2F, rd_data);
      check8(rd_data, 8'hC0);
      reg_write(8'h2F, 8'h80);
      pulse(14'h1000);
      check1(irq_out, 1'b1);
      reg_read(8'h34, rd_data);
      check8(rd_data, 8'h40);
      check1(irq_out, 1'b0);
      reg_write(8'h39, 8'hFF);
      reg_read(8'h39, rd_data);
      check8(rd_data, 8'h02);
      pulse(14'h0008);
      check1(irq_out, 1'b0);
      @(negedge core_clk_in);
      nrst_in = 1'b0;
      repeat (2) @(negedge core_clk_in);
      check1(irq_out, 1'b0);
      nrst_in = 1'b1;
      reg_read(8'h2F, rd_data);
      check8(rd_data, 8'hC0);
      reg_read(8'h39, rd_data);
      check8(rd_data, 8'h00);
      $display("test pll and reset done");
   endtask

   // main sequence
   initial begin
      fail_count = 0;
      cmp_count = 0;
      cycle_count = 0;
      nrst_in = 1'b0;
      events_in = fault_status_pkg::fault_events_s'(14'h0000);
      reg_addr_in = 8'h00;
      reg_wr_in = 1'b0;
      reg_wdata_in = 8'h00;
      reg_rd_in = 1'b0;
      repeat (16) @(negedge core_clk_in);
      nrst_in = 1'b1;
      test_reset_values();
      test_each_event();
      test_masks();
      test_set_wins();
      test_pll_and_reset();
      final_report();
   end
endmodule // latched_fault_interrupt_status_tb
`default_nettype wire
